// ==== core/ivpr_regs.svh ====
// Constants of the interrupt vector priority resolver: offsets, fields, tables.
// Assumes inclusion by bare name from the package and the resolver core.
// Operation
// - Each source owns one vector: NMI 11, break 12, pins 64 to 71.
// - Vector table entry lies at byte offset vector times four, four bytes long.
// - On acceptance the start address is fetched from that source's table entry.
// - Software sets level 0 to 15 per pin and peripheral group in 4-bit fields.
// - Sources sharing one field rank in fixed hardware order, A above B above C.
// - Power-on reset sets every programmable level to 0.
// - Equal levels pending together resolve in fixed default order, NMI first.
// - NMI is fixed level 16, break fixed level 15, never programmable.
// - Pins 0-3 use first register fields 15:12 down to 3:0, pins 4-7 the second.
// - DMA ends take vectors 72,76,80,84; timer 0 compares 88-91 share one field.
// - A source at level zero is masked and never presented.
// - Acceptance loads the mask with the source level; NMI and break load 15.
`ifndef IVPR_REGS_SVH
`define IVPR_REGS_SVH
`define IVPR_NSRC 25
`define IVPR_NFLD 20
`define IVPR_NPRIO 5
`define IVPR_LVL_W 4
`define IVPR_VEC_SHIFT 2
`define IVPR_VEC_NMI 8'h0B
`define IVPR_VEC_BRK 8'h0C
`define IVPR_LVL_NMI 5'h10
`define IVPR_LVL_BRK 5'h0F
`define IVPR_MASK_FIXED 4'hF
`define IVPR_PRIO_RST 16'h0000
`define IVPR_OFF_PRIO0 6'h00
`define IVPR_OFF_ISTAT 6'h14
`define IVPR_OFF_IMASK 6'h18
`define IVPR_OFF_STATE 6'h1C
`define IVPR_EV_ACC 0
`define IVPR_EV_NMI 1
// Source 24 first; index order is the default order
`define IVPR_VEC_TABLE {8'h6D, 8'h6C, 8'h69, 8'h68, 8'h65, 8'h64, 8'h61, 8'h60, \
  8'h5C, 8'h5B, 8'h5A, 8'h59, 8'h58, 8'h54, 8'h50, 8'h4C, 8'h48, \
  8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40}
`define IVPR_FLD_TABLE {5'h11, 5'h11, 5'h10, 5'h10, 5'h0F, 5'h0F, 5'h0E, 5'h0E, \
  5'h0D, 5'h0C, 5'h0C, 5'h0C, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, \
  5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
`endif

// ==== core/ivpr_pkg.sv ====
// Types shared by the resolver core.
// Assumes ivpr_regs.svh on the include path.
`include "ivpr_regs.svh"
package ivpr_pkg;
  typedef enum logic [0:0] {
    IVPR_IDLE = 1'b0,
    IVPR_FETCH = 1'b1
  } ivpr_state_e;
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic [4:0] level;
  } ivpr_win_s;
  typedef logic [`IVPR_NSRC*8-1:0] ivpr_vtab_t;
  typedef logic [`IVPR_NSRC*5-1:0] ivpr_ftab_t;
endpackage

// ==== core/ivpr_top.sv ====
// Interrupt vector priority resolver with Avalon-MM register slave.
// Assumes peripheral requests are levels on ref_clk_in held until serviced;
// pin sense and edge logic sit outside, pins arrive active high.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ivpr_regs.svh"
module ivpr_top (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Request sources
  input wire logic nmi_pin_in,
  input wire logic [7:0] external_request_pins_in,
  input wire logic break_request_in,
  input wire logic [3:0] dma_channel_end_request_in,
  input wire logic [12:0] timer_request_in,
  // Processor side
  input wire logic [3:0] processor_mask_level_in,
  input wire logic cpu_ack_in,
  output logic irq_req_out,
  output logic [7:0] vector_out,
  output logic [3:0] req_level_out,
  output logic fetch_out,
  output logic [9:0] fetch_addr_out,
  output logic mask_load_out,
  output logic [3:0] mask_level_out,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Interrupt to software
  output logic irq_out
);
  localparam ivpr_pkg::ivpr_vtab_t VTAB = `IVPR_VEC_TABLE;
  localparam ivpr_pkg::ivpr_ftab_t FTAB = `IVPR_FLD_TABLE;

  // Pin synchronisers
  logic [8:0] sync1_r, sync2_r;
  logic nmi_s;
  logic [7:0] pins_s;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
    end else begin
      sync1_r <= {nmi_pin_in, external_request_pins_in};
      sync2_r <= sync1_r;
    end
  end
  assign nmi_s = sync2_r[8];
  assign pins_s = sync2_r[7:0];

  // Priority fields
  logic [`IVPR_NPRIO-1:0][15:0] prio_r, prio_nxt;
  logic [`IVPR_NFLD-1:0][3:0] fld;
  genvar f;
  generate
    for (f = 0; f < `IVPR_NFLD; f++) begin : g_fld
      assign fld[f] = prio_r[f / 4][15 - 4 * (f % 4) -: `IVPR_LVL_W];
    end
  endgenerate

  // Per-source effective level
  logic [`IVPR_NSRC-1:0] src_req;
  logic [`IVPR_NSRC-1:0][3:0] src_lvl;
  assign src_req = {timer_request_in, dma_channel_end_request_in, pins_s};
  genvar s;
  generate
    for (s = 0; s < `IVPR_NSRC; s++) begin : g_src
      assign src_lvl[s] = src_req[s] ? fld[FTAB[s*5 +: 5]] : 4'h0;
    end
  endgenerate

  // Winner search; strict compare keeps the earlier index on ties
  ivpr_pkg::ivpr_win_s win;
  logic req_nxt;
  always_comb begin
    win = '0;
    if (nmi_s) begin
      win = '{1'b1, `IVPR_VEC_NMI, `IVPR_LVL_NMI};
    end else if (break_request_in) begin
      win = '{1'b1, `IVPR_VEC_BRK, `IVPR_LVL_BRK};
    end
    for (int i = 0; i < `IVPR_NSRC; i++) begin
      if ({1'b0, src_lvl[i]} > win.level) begin
        win = '{1'b1, VTAB[i*8 +: 8], {1'b0, src_lvl[i]}};
      end
    end
    req_nxt = win.valid &&
      (win.vector == `IVPR_VEC_NMI || win.level > {1'b0, processor_mask_level_in});
  end

  // Presentation and acceptance
  ivpr_pkg::ivpr_state_e st_r, st_nxt;
  logic irq_req_r, irq_req_nxt, fetch_r, fetch_nxt, mload_r, mload_nxt;
  logic [7:0] vec_r, vec_nxt, acc_r, acc_nxt;
  logic [3:0] lvl_r, lvl_nxt, mlvl_r, mlvl_nxt;
  logic accept;
  assign accept = cpu_ack_in && irq_req_r && st_r == ivpr_pkg::IVPR_IDLE;
  always_comb begin
    st_nxt = st_r;
    irq_req_nxt = 1'b0;
    vec_nxt = vec_r;
    lvl_nxt = lvl_r;
    acc_nxt = acc_r;
    mlvl_nxt = mlvl_r;
    fetch_nxt = 1'b0;
    mload_nxt = 1'b0;
    case (st_r)
      ivpr_pkg::IVPR_IDLE: begin
        if (accept) begin
          st_nxt = ivpr_pkg::IVPR_FETCH;
          acc_nxt = vec_r;
          fetch_nxt = 1'b1;
          mload_nxt = 1'b1;
          mlvl_nxt = (vec_r == `IVPR_VEC_NMI || vec_r == `IVPR_VEC_BRK) ?
            `IVPR_MASK_FIXED : lvl_r;
        end else begin
          irq_req_nxt = req_nxt;
          vec_nxt = win.vector;
          lvl_nxt = (win.level > {1'b0, `IVPR_MASK_FIXED}) ? `IVPR_MASK_FIXED : win.level[3:0];
        end
      end
      ivpr_pkg::IVPR_FETCH: begin
        // One dead cycle lets the source drop its request
        st_nxt = ivpr_pkg::IVPR_IDLE;
      end
      default: st_nxt = ivpr_pkg::IVPR_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= ivpr_pkg::IVPR_IDLE;
      irq_req_r <= 1'b0;
      vec_r <= 8'h00;
      lvl_r <= 4'h0;
      acc_r <= 8'h00;
      mlvl_r <= 4'h0;
      fetch_r <= 1'b0;
      mload_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      irq_req_r <= irq_req_nxt;
      vec_r <= vec_nxt;
      lvl_r <= lvl_nxt;
      acc_r <= acc_nxt;
      mlvl_r <= mlvl_nxt;
      fetch_r <= fetch_nxt;
      mload_r <= mload_nxt;
    end
  end
  assign irq_req_out = irq_req_r;
  assign vector_out = vec_r;
  assign req_level_out = lvl_r;
  assign fetch_out = fetch_r;
  assign fetch_addr_out = {acc_r, 2'b00};
  assign mask_load_out = mload_r;
  assign mask_level_out = mlvl_r;

  // Register slave; answers one cycle after the request appears
  logic ack_r, ack_nxt, irq_r, irq_nxt, wreq_r, wreq_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0] stat_r, stat_nxt, imask_r, imask_nxt;
  logic [15:0] wmask;
  logic hit_prio;
  logic [2:0] pidx;
  assign pidx = avs_address_in[4:2];
  assign hit_prio = avs_address_in[5] == 1'b0 && avs_address_in[1:0] == 2'b00 &&
    {3'h0, avs_address_in[4:0]} < {2'h0, `IVPR_OFF_ISTAT};
  assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  always_comb begin
    ack_nxt = (avs_read_in || avs_write_in) && !ack_r;
    wreq_nxt = !ack_nxt;
    prio_nxt = prio_r;
    imask_nxt = imask_r;
    rd_nxt = rd_r;
    stat_nxt = stat_r;
    if (ack_nxt && avs_read_in) begin
      rd_nxt = 32'h0000_0000;
      if (hit_prio) begin
        rd_nxt[15:0] = prio_r[pidx];
      end else begin
        case (avs_address_in)
          `IVPR_OFF_ISTAT: rd_nxt[1:0] = stat_r;
          `IVPR_OFF_IMASK: rd_nxt[1:0] = imask_r;
          `IVPR_OFF_STATE: rd_nxt[15:0] = {irq_req_r, 3'h0, lvl_r, vec_r};
          default: rd_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (ack_r && avs_write_in) begin
      if (hit_prio) begin
        prio_nxt[pidx] = (prio_r[pidx] & ~wmask) | (avs_writedata_in[15:0] & wmask);
      end else if (avs_byteenable_in[0]) begin
        case (avs_address_in)
          `IVPR_OFF_ISTAT: stat_nxt = stat_r & ~avs_writedata_in[1:0];
          `IVPR_OFF_IMASK: imask_nxt = avs_writedata_in[1:0];
          default: imask_nxt = imask_r;
        endcase
      end
    end
    // Set beats a clear landing in the same cycle
    if (accept) begin
      stat_nxt[`IVPR_EV_ACC] = 1'b1;
      stat_nxt[`IVPR_EV_NMI] = stat_nxt[`IVPR_EV_NMI] | (vec_r == `IVPR_VEC_NMI);
    end
    irq_nxt = |(stat_nxt & imask_nxt);
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      prio_r <= {`IVPR_NPRIO{`IVPR_PRIO_RST}};
      ack_r <= 1'b0;
      wreq_r <= 1'b1;
      rd_r <= 32'h0000_0000;
      stat_r <= 2'h0;
      imask_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      prio_r <= prio_nxt;
      ack_r <= ack_nxt;
      wreq_r <= wreq_nxt;
      rd_r <= rd_nxt;
      stat_r <= stat_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
    end
  end
  // Own flop so the pin carries no inverter after the register
  assign avs_waitrequest_out = wreq_r;
  assign avs_readdata_out = rd_r;
  assign irq_out = irq_r;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  nmi_always_wins_a: assert property (
    (nmi_s && st_r == ivpr_pkg::IVPR_IDLE && !accept) |=>
      irq_req_out && vector_out == `IVPR_VEC_NMI && req_level_out == `IVPR_MASK_FIXED)
    else $error("NMI not presented");
  break_over_pins_a: assert property (
    (!nmi_s && break_request_in && processor_mask_level_in != `IVPR_MASK_FIXED &&
      st_r == ivpr_pkg::IVPR_IDLE && !accept) |=> irq_req_out && vector_out == `IVPR_VEC_BRK)
    else $error("Break lost to a maskable source");
  zero_level_masked_a: assert property (
    (!nmi_s && !break_request_in && src_lvl == '0) |=> !irq_req_out)
    else $error("Level zero source presented");
  above_mask_a: assert property (
    (irq_req_out && vector_out != `IVPR_VEC_NMI) |-> $past(processor_mask_level_in) < req_level_out)
    else $error("Request not above mask");
  mask_load_value_a: assert property (
    (accept && vector_out >= `IVPR_VEC_BRK + 8'h01) |=> mask_load_out && mask_level_out == $past(lvl_r))
    else $error("Mask load level wrong");
  fetch_entry_addr_a: assert property (
    accept |=> fetch_out && fetch_addr_out == {$past(vector_out), 2'b00} ##1 !fetch_out)
    else $error("Fetch address wrong");
  reset_levels_zero_a: assert property (
    $past(reset_in) |-> prio_r == '0)
    else $error("Levels not cleared by reset");
  bus_one_wait_a: assert property (
    ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Bus answer timing wrong");
  irq_follows_status_a: assert property (
    irq_out == |(stat_r & imask_r))
    else $error("Interrupt output stale");

  // Status, handshake and synchroniser checks
  status_set_wins_a: assert property (
    accept |=> stat_r[`IVPR_EV_ACC])
    else $error("Accept status bit lost");
  nmi_status_set_a: assert property (
    (accept && vector_out == `IVPR_VEC_NMI) |=> stat_r[`IVPR_EV_NMI])
    else $error("NMI status bit lost");
  fixed_mask_load_a: assert property (
    (accept && vector_out <= `IVPR_VEC_BRK) |=>
      mask_load_out && mask_level_out == `IVPR_MASK_FIXED)
    else $error("Fixed mask level wrong");
  req_gap_after_ack_a: assert property (
    accept |=> !irq_req_out ##1 !irq_req_out)
    else $error("Request not withdrawn after accept");
  req_level_nonzero_a: assert property (
    irq_req_out |-> req_level_out != 4'h0)
    else $error("Request presented at level zero");
  break_full_mask_a: assert property (
    (!nmi_s && break_request_in && processor_mask_level_in == `IVPR_MASK_FIXED &&
      st_r == ivpr_pkg::IVPR_IDLE) |=> !irq_req_out)
    else $error("Break presented under full mask");
  prio_write_only_a: assert property (
    !(avs_write_in && !avs_waitrequest_out) |=> prio_r == $past(prio_r))
    else $error("Level register changed without a write");
  bus_idle_wait_a: assert property (
    !(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
    else $error("Bus answered without a request");
  fetch_pulse_a: assert property (
    fetch_out |-> mask_load_out ##1 !fetch_out)
    else $error("Fetch pulse malformed");
  pin_sync_depth_a: assert property (
    (!$past(reset_in) && !$past(reset_in, 2)) |->
      pins_s == $past(external_request_pins_in, 2))
    else $error("Pin synchroniser depth wrong");
endmodule

// ==== dv/ivpr_cpu_model.sv ====
// CPU core stand-in: acknowledges requests and keeps the mask level.
// Assumes the resolver on the same clock.
`timescale 1ns/1ps
module ivpr_cpu_model (
  // Clock and control
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic en_in,
  input wire logic slow_in,
  input wire logic restore_in,
  input wire logic [3:0] base_in,
  // Resolver side
  input wire logic irq_req_in,
  input wire logic mask_load_in,
  input wire logic [3:0] mask_level_in,
  output logic ack_out,
  output logic [3:0] mask_out
);
  logic [1:0] wait_r;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ack_out <= 1'b0;
      wait_r <= 2'h0;
      mask_out <= 4'h0;
    end else begin
      // Slow mode lets the request stand first
      ack_out <= en_in && irq_req_in && !ack_out && (!slow_in || wait_r == 2'h3);
      wait_r <= (irq_req_in && !ack_out) ? wait_r + 2'h1 : 2'h0;
      mask_out <= restore_in ? base_in : (mask_load_in ? mask_level_in : mask_out);
    end
  end
endmodule

// ==== dv/tb_interrupt_vector_priority_resolver.sv ====
// Self-checking bench of the resolver against a CPU stand-in.
// Assumes core/ files compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_interrupt_vector_priority_resolver;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, nmi_pin_in = 1'b0, break_request_in = 1'b0;
  logic [7:0] external_request_pins_in = 8'h00;
  logic [3:0] dma_channel_end_request_in = 4'h0, processor_mask_level_in, base = 4'h0;
  logic [12:0] timer_request_in = 13'h0000;
  logic cpu_ack_in, irq_req_out, fetch_out, mask_load_out, irq_out;
  logic [7:0] vector_out;
  logic [3:0] req_level_out, mask_level_out;
  logic [9:0] fetch_addr_out;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
  logic en = 1'b0, slow = 1'b0, restore = 1'b0, nmi_acc = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [15:0] lv [5] = '{default: 16'h0000};
  int failures = 0, checked = 0;
  ivpr_top dut_u (.ref_clk_in, .reset_in, .nmi_pin_in, .external_request_pins_in,
    .break_request_in, .dma_channel_end_request_in, .timer_request_in,
    .processor_mask_level_in, .cpu_ack_in, .irq_req_out, .vector_out, .req_level_out,
    .fetch_out, .fetch_addr_out, .mask_load_out, .mask_level_out, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .irq_out);
  ivpr_cpu_model cpu_u (.ref_clk_in, .reset_in, .en_in(en), .slow_in(slow),
    .restore_in(restore), .base_in(base), .irq_req_in(irq_req_out),
    .mask_load_in(mask_load_out), .mask_level_in(mask_level_out), .ack_out(cpu_ack_in),
    .mask_out(processor_mask_level_in));
  always #50 ref_clk_in = ~ref_clk_in;
  task automatic print_verdict;
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    // No local limit: only the watchdog ends a hung handshake
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    r = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  // Source index: NMI, break, pins 0-7, DMA 0-3, timer bits 0-12
  function automatic logic [4:0] lvl(int s);
    int f;
    if (s < 2) return s ? 5'h0F : 5'h10;
    f = s < 14 ? s - 2 : (s < 18 ? 12 : (s == 18 ? 13 : 14 + (s - 19) / 2));
    return 5'(lv[f / 4] >> (12 - 4 * (f % 4))) & 5'h0F;
  endfunction
  function automatic logic [7:0] vec_of(int s);
    logic [7:0] tv [13] = '{8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h60, 8'h61, 8'h64,
      8'h65, 8'h68, 8'h69, 8'h6C, 8'h6D};
    if (s < 2) return 8'h0B + 8'(s);
    if (s < 10) return 8'h40 + 8'(s - 2);
    if (s < 14) return 8'h48 + 8'(4 * (s - 10));
    return tv[s - 14];
  endfunction
  function automatic int winner(logic [26:0] p, logic [3:0] m);
    int w;
    logic [4:0] b;
    w = -1;
    b = 5'h00;
    // Strictly greater keeps the earlier source on a tie
    for (int s = 0; s < 27; s++) begin
      if (p[s] && lvl(s) > b && (s == 0 || lvl(s) > {1'b0, m})) begin
        w = s;
        b = lvl(s);
      end
    end
    return w;
  endfunction
  task automatic trial(int t);
    logic [26:0] p;
    int w, n;
    logic seen;
    logic [9:0] fa;
    logic [7:0] vo;
    logic [3:0] ml, rl, el;
    // First trial keeps the reset levels
    if (t > 0) for (int r = 0; r < 5; r++) begin
      lv[r] = 16'($urandom);
      bus(1'b1, 6'(4 * r), {16'h0000, lv[r]}, q);
    end
    bus(1'b0, 6'(4 * (t % 5)), 32'h0, q);
    `CHK("level reg", {16'h0000, lv[t % 5]}, q)
    base <= ($urandom_range(0, 3) == 0) ? 4'($urandom) : 4'h0;
    slow <= t[0];
    restore <= 1'b1;
    @(posedge ref_clk_in);
    restore <= 1'b0;
    p = 27'($urandom & $urandom & $urandom);
    p[0] = ($urandom_range(0, 7) == 0);
    {timer_request_in, dma_channel_end_request_in, external_request_pins_in} <= p[26:2];
    {break_request_in, nmi_pin_in} <= p[1:0];
    repeat (4) @(posedge ref_clk_in);
    en <= 1'b1;
    w = winner(p, base);
    seen = 1'b0;
    for (n = 0; n < 40 && !seen; n++) begin
      @(posedge ref_clk_in);
      if (cpu_ack_in === 1'b1 && irq_req_out === 1'b1) {vo, rl} = {vector_out, req_level_out};
      if (fetch_out === 1'b1) begin
        {seen, fa, ml} = {1'b1, fetch_addr_out, mask_level_out};
        en <= 1'b0;
      end
    end
    {timer_request_in, dma_channel_end_request_in, external_request_pins_in} <= 25'h0;
    {break_request_in, nmi_pin_in, en} <= 3'h0;
    `CHK("accepted", w >= 0, seen)
    if (w == 0 && seen === 1'b1) nmi_acc = 1'b1;
    if (w >= 0 && seen === 1'b1) begin
      el = w < 2 ? 4'hF : 4'(lvl(w));
      `CHK("vector", vec_of(w), vo)
      `CHK("req level", el, rl)
      `CHK("fetch addr", {vec_of(w), 2'b00}, fa)
      `CHK("mask level", el, ml)
    end
    repeat (6) @(posedge ref_clk_in);
  endtask
  initial begin
    void'($urandom(32'h87CD));
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 6'(4 * i), 32'h0, q);
      `CHK("reset level", 32'h0, q)
    end
    bus(1'b1, 6'h20, 32'hFFFF, q);
    bus(1'b0, 6'h20, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    for (int t = 0; t < 40; t++) trial(t);
    bus(1'b0, 6'h14, 32'h0, q);
    `CHK("status", 1'b1, q[0])
    `CHK("nmi status", nmi_acc, q[1])
    `CHK("irq masked", 1'b0, irq_out)
    bus(1'b1, 6'h18, 32'h3, q);
    repeat (2) @(posedge ref_clk_in);
    `CHK("irq raised", 1'b1, irq_out)
    bus(1'b1, 6'h14, 32'h3, q);
    repeat (2) @(posedge ref_clk_in);
    `CHK("irq cleared", 1'b0, irq_out)
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    print_verdict;
  end
endmodule
